// file: rtl/agcgl_top.sv
/*
  Gain limit, amplitude target and carrier sense block: two configuration
  registers, amplitude steering, gain stage state and carrier sense.
  Assumes the register port and the channel filter amplitude are on sys_clk.
*/
//
// Overview of operation
// - Digital gain ceiling bits 7:6 bar the top N amplifier settings; zero allows all.
// - Front gain ceiling bits 5:3 cap combined front stage gain; zero allows full.
// - Amplitude target bits 2:0, reset code 3, set the steering amplitude.
// - Target codes 0..7 mean 24, 27, 30, 33, 36, 38, 40, 42 dB.
// - Stage priority bit 6 set: reduce the first front stage before others.
// - Stage priority clear: second front stage to minimum, then the first.
// - Relative sense threshold bits 5:4 at zero disable relative carrier sense.
// - Relative codes 1, 2, 3 assert carrier sense on 6, 10, 14 dB rise.
// - Absolute sense threshold bits 3:0 are signed dB offsets from the target.
// - Absolute code -8 disables; -7..+7 put threshold that many dB off target.
// - Absolute threshold is compared with amplitude before any gain reduction.
`timescale 1ns/1ps
`default_nettype none
module agcgl_top
  import agcgl_pkg::*;
#(
  parameter int DIG_MAX = 7,
  parameter int FRONT_MAX = 4,
  parameter int FRONT_STEP_DB = 3,
  parameter int DIG_STEP_DB = 3
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [5:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rd_data,
  input wire logic amp_valid,
  input wire logic [7:0] amp_db,
  output logic [2:0] digital_setting,
  output logic [2:0] front1_reduction,
  output logic [2:0] front2_reduction,
  output logic [7:0] target_db,
  output logic carrier_sense
);

  typedef struct packed {
    logic [7:0] gain_ceiling_and_target;
    logic [7:0] stage_priority_and_sense_thresholds;
    logic [7:0] rd_data;
    logic [7:0] target;
    logic step_down;
    logic step_up;
  } agcgl_top_state_t;

  agcgl_top_state_t s_q;
  agcgl_top_state_t s_d;

  logic [1:0] digital_gain_ceiling;
  logic [2:0] front_gain_ceiling;
  logic [2:0] amplitude_target;
  logic stage_priority;
  logic [1:0] relative_sense_threshold;
  logic [3:0] absolute_sense_threshold;
  logic [7:0] reduction_db;

  // ----------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------
  assign digital_gain_ceiling = s_q.gain_ceiling_and_target[AGCGL_DIG_CEIL_LSB +: 2];
  assign front_gain_ceiling = s_q.gain_ceiling_and_target[AGCGL_FRONT_CEIL_LSB +: 3];
  assign amplitude_target = s_q.gain_ceiling_and_target[AGCGL_TARGET_LSB +: 3];
  assign stage_priority = s_q.stage_priority_and_sense_thresholds[AGCGL_PRIORITY_BIT];
  assign relative_sense_threshold =
    s_q.stage_priority_and_sense_thresholds[AGCGL_REL_THR_LSB +: 2];
  assign absolute_sense_threshold =
    s_q.stage_priority_and_sense_thresholds[AGCGL_ABS_THR_LSB +: 4];

  // ----------------------------------------------------------------
  // Register file and steering
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.step_down = 1'b0;
    s_d.step_up = 1'b0;
    if (reg_wr_en)
    begin
      case (reg_addr)
        AGCGL_ADDR_GAIN_CEIL:
          s_d.gain_ceiling_and_target = reg_wr_data & AGCGL_MASK_GAIN_CEIL;
        AGCGL_ADDR_STAGE_SENSE:
          s_d.stage_priority_and_sense_thresholds = reg_wr_data & AGCGL_MASK_STAGE_SENSE;
        default:
          s_d.rd_data = s_q.rd_data;
      endcase
    end
    if (reg_rd_en)
    begin
      case (reg_addr)
        AGCGL_ADDR_GAIN_CEIL:
          s_d.rd_data = s_q.gain_ceiling_and_target;
        AGCGL_ADDR_STAGE_SENSE:
          s_d.rd_data = s_q.stage_priority_and_sense_thresholds;
        default:
          s_d.rd_data = 8'h00;
      endcase
    end
    s_d.target = agcgl_target_db(amplitude_target);
    // Steer the averaged amplitude toward the target one step per sample
    if (amp_valid)
    begin
      s_d.step_down = amp_db > s_q.target;
      s_d.step_up = amp_db < s_q.target;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_q.gain_ceiling_and_target <= AGCGL_RST_GAIN_CEIL;
      s_q.stage_priority_and_sense_thresholds <= AGCGL_RST_STAGE_SENSE;
      s_q.rd_data <= 8'h00;
      s_q.target <= 8'h21;
      s_q.step_down <= 1'b0;
      s_q.step_up <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign reg_rd_data = s_q.rd_data;
  assign target_db = s_q.target;

  // ----------------------------------------------------------------
  // Gain stages and carrier sense
  // ----------------------------------------------------------------
  agcgl_gain #(
    .DIG_MAX(DIG_MAX),
    .FRONT_MAX(FRONT_MAX),
    .FRONT_STEP_DB(FRONT_STEP_DB),
    .DIG_STEP_DB(DIG_STEP_DB)
  ) u_agcgl_gain (
    .sys_clk(sys_clk),
    .rst(rst),
    .step_down(s_q.step_down),
    .step_up(s_q.step_up),
    .digital_gain_ceiling(digital_gain_ceiling),
    .front_gain_ceiling(front_gain_ceiling),
    .stage_priority(stage_priority),
    .digital_setting(digital_setting),
    .front1_reduction(front1_reduction),
    .front2_reduction(front2_reduction),
    .reduction_db(reduction_db)
  );

  agcgl_sense u_agcgl_sense (
    .sys_clk(sys_clk),
    .rst(rst),
    .amp_valid(amp_valid),
    .amp_db(amp_db),
    .reduction_db(reduction_db),
    .target_db(s_q.target),
    .relative_sense_threshold(relative_sense_threshold),
    .absolute_sense_threshold(absolute_sense_threshold),
    .carrier_sense(carrier_sense)
  );

endmodule
`default_nettype wire

// file: shared/agcgl_pkg.sv
/*
  Constants, register layout and decode functions for the gain limit and
  carrier sense block.
  Assumes a single system clock domain and a synchronous active-high reset.
*/
package agcgl_pkg;

  // ----------------------------------------------------------------
  // Register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] AGCGL_ADDR_GAIN_CEIL = 6'h1b;
  localparam logic [5:0] AGCGL_ADDR_STAGE_SENSE = 6'h1c;
  localparam logic [7:0] AGCGL_RST_GAIN_CEIL = 8'h03;
  localparam logic [7:0] AGCGL_RST_STAGE_SENSE = 8'h40;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int AGCGL_DIG_CEIL_LSB = 6;
  localparam int AGCGL_FRONT_CEIL_LSB = 3;
  localparam int AGCGL_TARGET_LSB = 0;
  localparam int AGCGL_PRIORITY_BIT = 6;
  localparam int AGCGL_REL_THR_LSB = 4;
  localparam int AGCGL_ABS_THR_LSB = 0;

  // Written-value masks: bit 7 of the second register is not used
  localparam logic [7:0] AGCGL_MASK_GAIN_CEIL = 8'hff;
  localparam logic [7:0] AGCGL_MASK_STAGE_SENSE = 8'h7f;

  // ----------------------------------------------------------------
  // Threshold encodings
  // ----------------------------------------------------------------
  localparam logic [3:0] AGCGL_ABS_DISABLED = 4'h8;
  localparam logic [7:0] AGCGL_REL_DB_1 = 8'h06;
  localparam logic [7:0] AGCGL_REL_DB_2 = 8'h0a;
  localparam logic [7:0] AGCGL_REL_DB_3 = 8'h0e;

  // Gain state after reset: full gain everywhere
  localparam logic [2:0] AGCGL_FRONT_RED_RST = 3'h0;

  // Amplitude target code to dB
  function automatic logic [7:0] agcgl_target_db(input logic [2:0] code);
    case (code)
      3'h0: agcgl_target_db = 8'h18;
      3'h1: agcgl_target_db = 8'h1b;
      3'h2: agcgl_target_db = 8'h1e;
      3'h3: agcgl_target_db = 8'h21;
      3'h4: agcgl_target_db = 8'h24;
      3'h5: agcgl_target_db = 8'h26;
      3'h6: agcgl_target_db = 8'h28;
      default: agcgl_target_db = 8'h2a;
    endcase
  endfunction

  // Relative threshold code to dB rise, zero means disabled
  function automatic logic [7:0] agcgl_rel_db(input logic [1:0] code);
    case (code)
      2'h1: agcgl_rel_db = AGCGL_REL_DB_1;
      2'h2: agcgl_rel_db = AGCGL_REL_DB_2;
      2'h3: agcgl_rel_db = AGCGL_REL_DB_3;
      default: agcgl_rel_db = 8'h00;
    endcase
  endfunction

endpackage

// file: rtl/agcgl_gain.sv
/*
  Gain stage state for the digital amplifier and the two front stages.
  Assumes one-cycle step requests on sys_clk and static ceilings from the
  register file.
*/
`timescale 1ns/1ps
`default_nettype none
module agcgl_gain
  import agcgl_pkg::*;
#(
  parameter int DIG_MAX = 7,
  parameter int FRONT_MAX = 4,
  parameter int FRONT_STEP_DB = 3,
  parameter int DIG_STEP_DB = 3
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic step_down,
  input wire logic step_up,
  input wire logic [1:0] digital_gain_ceiling,
  input wire logic [2:0] front_gain_ceiling,
  input wire logic stage_priority,
  output logic [2:0] digital_setting,
  output logic [2:0] front1_reduction,
  output logic [2:0] front2_reduction,
  output logic [7:0] reduction_db
);

  typedef struct packed {
    logic [2:0] dig;
    logic [2:0] red1;
    logic [2:0] red2;
    logic [7:0] red_db;
  } agcgl_gain_state_t;

  localparam logic [2:0] DMAX = 3'(DIG_MAX);
  localparam logic [2:0] FMAX = 3'(FRONT_MAX);

  agcgl_gain_state_t s_q;
  agcgl_gain_state_t s_d;

  logic [2:0] dig_lim;
  logic [3:0] front_tot;

  always_comb
  begin
    s_d = s_q;
    dig_lim = DMAX - {1'b0, digital_gain_ceiling};
    front_tot = {1'b0, s_q.red1} + {1'b0, s_q.red2};
    if (s_q.dig > dig_lim)
    begin
      s_d.dig = dig_lim;
    end
    else if (front_tot < {1'b0, front_gain_ceiling})
    begin
      // Pull front gain down to the ceiling in priority order
      if (stage_priority && s_q.red1 < FMAX)
        s_d.red1 = s_q.red1 + 3'h1;
      else if (s_q.red2 < FMAX)
        s_d.red2 = s_q.red2 + 3'h1;
      else
        s_d.red1 = s_q.red1 + 3'h1;
    end
    else if (step_down)
    begin
      if (stage_priority && s_q.red1 < FMAX)
        s_d.red1 = s_q.red1 + 3'h1;
      else if (s_q.red2 < FMAX)
        s_d.red2 = s_q.red2 + 3'h1;
      else if (s_q.red1 < FMAX)
        s_d.red1 = s_q.red1 + 3'h1;
      else if (s_q.dig > 3'h0)
        s_d.dig = s_q.dig - 3'h1;
    end
    else if (step_up)
    begin
      if (s_q.dig < dig_lim)
        s_d.dig = s_q.dig + 3'h1;
      else if (front_tot > {1'b0, front_gain_ceiling})
      begin
        // Undo front reduction in the reverse of the reducing order
        if (stage_priority && s_q.red2 != 3'h0)
          s_d.red2 = s_q.red2 - 3'h1;
        else if (!stage_priority && s_q.red1 != 3'h0)
          s_d.red1 = s_q.red1 - 3'h1;
        else if (s_q.red1 != 3'h0)
          s_d.red1 = s_q.red1 - 3'h1;
        else
          s_d.red2 = s_q.red2 - 3'h1;
      end
    end
    s_d.red_db = 8'(({5'h0, s_d.red1} + {5'h0, s_d.red2}) * 8'(FRONT_STEP_DB)
      + {5'h0, DMAX - s_d.dig} * 8'(DIG_STEP_DB));
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_q.dig <= DMAX;
      s_q.red1 <= AGCGL_FRONT_RED_RST;
      s_q.red2 <= AGCGL_FRONT_RED_RST;
      s_q.red_db <= 8'h00;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign digital_setting = s_q.dig;
  assign front1_reduction = s_q.red1;
  assign front2_reduction = s_q.red2;
  assign reduction_db = s_q.red_db;

endmodule
`default_nettype wire

// file: rtl/agcgl_sense.sv
/*
  Carrier sense decision from relative and absolute signal-strength thresholds.
  Assumes amplitude samples with a one-cycle valid strobe on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module agcgl_sense
  import agcgl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic amp_valid,
  input wire logic [7:0] amp_db,
  input wire logic [7:0] reduction_db,
  input wire logic [7:0] target_db,
  input wire logic [1:0] relative_sense_threshold,
  input wire logic [3:0] absolute_sense_threshold,
  output logic carrier_sense
);

  typedef struct packed {
    logic [7:0] base;
    logic rel_hit;
    logic abs_hit;
    logic cs;
  } agcgl_sense_state_t;

  agcgl_sense_state_t s_q;
  agcgl_sense_state_t s_d;

  logic [7:0] rel_db;
  logic signed [10:0] unreduced;
  logic signed [10:0] abs_thr;

  always_comb
  begin
    s_d = s_q;
    rel_db = agcgl_rel_db(relative_sense_threshold);
    // Amplitude as it would be with no gain reduction applied
    unreduced = signed'({3'h0, amp_db}) + signed'({3'h0, reduction_db});
    abs_thr = signed'({3'h0, target_db})
      + 11'(signed'(absolute_sense_threshold));
    if (amp_valid)
    begin
      s_d.rel_hit = (rel_db != 8'h00)
        && ({1'b0, amp_db} >= {1'b0, s_q.base} + {1'b0, rel_db});
      s_d.abs_hit = (absolute_sense_threshold != AGCGL_ABS_DISABLED)
        && (unreduced >= abs_thr);
      // Baseline follows the signal only while no relative rise is seen
      if (!s_d.rel_hit)
        s_d.base = amp_db;
    end
    if (relative_sense_threshold == 2'h0)
      s_d.rel_hit = 1'b0;
    if (absolute_sense_threshold == AGCGL_ABS_DISABLED)
      s_d.abs_hit = 1'b0;
    s_d.cs = s_d.rel_hit | s_d.abs_hit;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign carrier_sense = s_q.cs;

endmodule
`default_nettype wire

// file: sim/agcgl_props.sv
/*
  Port checker for the gain limit and carrier sense block.
  Assumes it is bound to agcgl_top and that all ports share sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module agcgl_props
  import agcgl_pkg::*;
#(
  parameter int FRONT_MAX = 4,
  parameter int FRONT_STEP_DB = 3,
  parameter int DIG_STEP_DB = 3
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [5:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_rd_data,
  input wire logic amp_valid,
  input wire logic [7:0] amp_db,
  input wire logic [2:0] digital_setting,
  input wire logic [2:0] front1_reduction,
  input wire logic [2:0] front2_reduction,
  input wire logic [7:0] target_db,
  input wire logic carrier_sense
);
  localparam logic [7:0] TGT_DB [8] = '{8'h18, 8'h1b, 8'h1e, 8'h21, 8'h24, 8'h26, 8'h28, 8'h2a};
  logic [7:0] gain_q;
  logic [6:0] sense_q;
  logic [3:0] quiet_q;
  logic [7:0] rd_exp;
  logic abs_hit;
  // ------------------------------------------------
  // Shadow registers and cycles since last write
  // ------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      gain_q <= 8'h03;
      sense_q <= 7'h40;
      quiet_q <= 4'h0;
    end
    else
    begin
      if (reg_wr_en && reg_addr == 6'h1b)
        gain_q <= reg_wr_data;
      if (reg_wr_en && reg_addr == 6'h1c)
        sense_q <= reg_wr_data[6:0];
      quiet_q <= reg_wr_en ? 4'h0 : ((quiet_q == 4'hf) ? quiet_q : quiet_q + 4'h1);
    end
  end
  always_comb
  begin
    rd_exp = 8'h00;
    if (reg_addr == 6'h1b)
      rd_exp = gain_q;
    if (reg_addr == 6'h1c)
      rd_exp = {1'b0, sense_q};
    abs_hit = (int'(amp_db) + (int'(front1_reduction) + int'(front2_reduction)) * FRONT_STEP_DB
      + (7 - int'(digital_setting)) * DIG_STEP_DB)
      >= (int'(TGT_DB[gain_q[2:0]]) + int'($signed(sense_q[3:0])));
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence abs_sample;
    amp_valid && sense_q[5:4] == 2'h0 && sense_q[3:0] != 4'h8 && quiet_q > 4'h3;
  endsequence
  rd_data_a: assert property (reg_rd_en |=> reg_rd_data == $past(rd_exp))
    else $error("read data differs from register contents");
  target_map_a: assert property (quiet_q > 4'h2 |-> target_db == TGT_DB[gain_q[2:0]])
    else $error("target amplitude differs from code");
  dig_ceil_a: assert property (quiet_q > 4'h3 |->
    digital_setting <= 3'h7 - {1'b0, gain_q[7:6]})
    else $error("digital setting above ceiling");
  front_ceil_a: assert property (quiet_q > 4'hb |->
    ({1'b0, front1_reduction} + {1'b0, front2_reduction}) >= {1'b0, gain_q[5:3]})
    else $error("front stage gain above ceiling");
  prio_first_a: assert property (sense_q[6] && quiet_q > 4'h2
    && front2_reduction > $past(front2_reduction) |-> front1_reduction == FRONT_MAX)
    else $error("second stage reduced before first");
  prio_second_a: assert property (!sense_q[6] && quiet_q > 4'h2
    && front1_reduction > $past(front1_reduction) |-> front2_reduction == FRONT_MAX)
    else $error("first stage reduced before second at minimum");
  sense_off_a: assert property (quiet_q > 4'h2 && sense_q[5:0] == 6'h08
    |-> !carrier_sense)
    else $error("carrier sense with both thresholds off");
  abs_sense_a: assert property (abs_sample |=>
    carrier_sense == $past(abs_hit))
    else $error("absolute carrier sense decision wrong");
endmodule
`default_nettype wire

// file: sim/agcgl_chan_model.sv
/*
  Receive chain and channel filter model: turns an unreduced input level
  into reduced amplitude samples.
  Assumes the gain outputs of agcgl_top and 3 dB per step.
*/
`timescale 1ns/1ps
`default_nettype none
module agcgl_chan_model
#(
  parameter int PERIOD = 4
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] level_db,
  input wire logic [2:0] digital_setting,
  input wire logic [2:0] front1_reduction,
  input wire logic [2:0] front2_reduction,
  output logic amp_valid,
  output logic [7:0] amp_db
);
  int cnt = 0;
  int red;
  logic [7:0] val;
  initial
  begin
    amp_valid = 1'b0;
    amp_db = 8'h00;
  end
  // Between samples the amplitude bus shows a changing pattern
  always @(negedge sys_clk)
  begin
    red = (int'(front1_reduction) + int'(front2_reduction)) * 3 + (7 - int'(digital_setting)) * 3;
    cnt = rst ? 0 : (cnt + 1) % PERIOD;
    val = (int'(level_db) > red) ? level_db - 8'(red) : 8'h00;
    amp_valid <= !rst && cnt == 0;
    amp_db <= (cnt == 0) ? val : ~amp_db;
  end
endmodule
`default_nettype wire

// file: sim/agcgl_top_tb.sv
/*
  Self-checking testbench for agcgl_top with a channel model.
  Assumes the checker agcgl_props is compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none
module agcgl_top_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] reg_addr = 6'h00;
  logic reg_wr_en = 1'b0;
  logic [7:0] reg_wr_data = 8'h00;
  logic reg_rd_en = 1'b0;
  logic [7:0] reg_rd_data;
  logic amp_valid;
  logic [7:0] amp_db;
  logic [7:0] level_db = 8'h00;
  logic [2:0] digital_setting;
  logic [2:0] front1_reduction;
  logic [2:0] front2_reduction;
  logic [7:0] target_db;
  logic carrier_sense;
  logic [7:0] v;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  always #50 sys_clk = ~sys_clk;
  agcgl_top u_agcgl_top (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
    .reg_rd_data(reg_rd_data), .amp_valid(amp_valid), .amp_db(amp_db),
    .digital_setting(digital_setting), .front1_reduction(front1_reduction),
    .front2_reduction(front2_reduction), .target_db(target_db), .carrier_sense(carrier_sense));
  agcgl_chan_model u_agcgl_chan_model (.sys_clk(sys_clk), .rst(rst), .level_db(level_db),
    .digital_setting(digital_setting), .front1_reduction(front1_reduction),
    .front2_reduction(front2_reduction), .amp_valid(amp_valid), .amp_db(amp_db));
  // ------------------------------------------------
  // Shared tasks
  // ------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic do_reset;
    rst = 1'b1;
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    @(negedge sys_clk);
    reg_wr_en = 1'b0;
  endtask
  task automatic rd(input logic [5:0] a);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge sys_clk);
    reg_rd_en = 1'b0;
    v = reg_rd_data;
  endtask
  task automatic lvl(input logic [7:0] l);
    level_db = l;
    repeat (16) @(negedge sys_clk);
  endtask
  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task automatic t_regs;
    rd(6'h1b);
    check(v, 8'h03);
    rd(6'h1c);
    check(v, 8'h40);
    wr(6'h1c, 8'hff);
    rd(6'h1c);
    check(v, 8'h7f);
    rd(6'h1d);
    check(v, 8'h00);
    wr(6'h1c, 8'h40);
  endtask
  task automatic t_target;
    logic [7:0] tdb [8] = '{8'h18, 8'h1b, 8'h1e, 8'h21, 8'h24, 8'h26, 8'h28, 8'h2a};
    for (int i = 0; i < 8; i++)
    begin
      wr(6'h1b, {5'h00, 3'(i)});
      repeat (3) @(negedge sys_clk);
      check(target_db, tdb[i]);
    end
  endtask
  task automatic t_ceil;
    do_reset();
    wr(6'h1b, 8'hfb);
    repeat (14) @(negedge sys_clk);
    check(8'(digital_setting), 8'h04);
    check(8'(front1_reduction), 8'h04);
    check(8'(front2_reduction), 8'h03);
    wr(6'h1b, 8'h43);
    repeat (14) @(negedge sys_clk);
    check(8'(digital_setting), 8'h06);
    wr(6'h1b, 8'h83);
    repeat (3) @(negedge sys_clk);
    check(8'(digital_setting), 8'h05);
  endtask
  task automatic t_prio0;
    do_reset();
    wr(6'h1c, 8'h08);
    lvl(8'h3c);
    repeat (64) @(negedge sys_clk);
    check(8'(front2_reduction), 8'h04);
    check(8'(front1_reduction), 8'h04);
    check(8'(digital_setting), 8'h06);
  endtask
  task automatic t_abs;
    do_reset();
    wr(6'h1c, 8'h42);
    lvl(8'h22);
    check(8'(carrier_sense), 8'h00);
    lvl(8'h23);
    check(8'(carrier_sense), 8'h01);
    wr(6'h1c, 8'h48);
    lvl(8'h3c);
    check(8'(carrier_sense), 8'h00);
    wr(6'h1c, 8'h49);
    lvl(8'h1a);
    check(8'(carrier_sense), 8'h01);
    wr(6'h1c, 8'h52);
    lvl(8'h24);
    check(8'(carrier_sense), 8'h01);
    lvl(8'h14);
    check(8'(carrier_sense), 8'h00);
    wr(6'h1c, 8'h47);
    lvl(8'h27);
    check(8'(carrier_sense), 8'h00);
    lvl(8'h28);
    check(8'(carrier_sense), 8'h01);
  endtask
  task automatic t_rel;
    logic [7:0] th [4] = '{8'h0e, 8'h06, 8'h0a, 8'h0e};
    do_reset();
    for (int c = 0; c < 4; c++)
    begin
      wr(6'h1c, {2'h1, 2'(c), 4'h8});
      lvl(8'h0f);
      lvl(8'h0e + th[c]);
      check(8'(carrier_sense), 8'h00);
      lvl(8'h0f);
      lvl(8'h0f + th[c]);
      check(8'(carrier_sense), {7'h00, c != 0});
      lvl(8'h0f);
    end
  endtask
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      n_errors++;
      complete_run();
    end
  end
  initial
  begin
    do_reset();
    t_regs();
    t_target();
    t_ceil();
    t_prio0();
    t_abs();
    t_rel();
    complete_run();
  end
endmodule
bind agcgl_top agcgl_props #(.FRONT_MAX(FRONT_MAX), .FRONT_STEP_DB(FRONT_STEP_DB),
  .DIG_STEP_DB(DIG_STEP_DB)) u_agcgl_props (.sys_clk(sys_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
  .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .amp_valid(amp_valid),
  .amp_db(amp_db), .digital_setting(digital_setting), .front1_reduction(front1_reduction),
  .front2_reduction(front2_reduction), .target_db(target_db), .carrier_sense(carrier_sense));
`default_nettype wire
